// [logic/tioms_pkg.sv]
// Functional notes
// RULE1 - Top bit 0: compare; 0000 disables, reset
// RULE2 - Second bit 0: initial pin level low
// RULE3 - Second bit 1: initial high; pair 00 disables
// RULE4 - Pair 01: pin low on compare match
// RULE5 - Pair 10: pin high on compare match
// RULE6 - Pair 11: pin toggles on compare match
// RULE7 - Top bit 1: capture counter on event
// RULE8 - Second bit 0: event from own pin
// RULE9 - Pair 00 rising edge, 01 falling edge
// RULE10 - Third bit 1: capture on both edges
// RULE11 - Channel 3 C, 11xx: channel 4 count
// RULE12 - Channel 4 A, 11xx: channel 3 A event
// RULE13 - Buffer mode A: channel 3 C does nothing; the code still enables its pin for one cycle on the write setting it
// RULE14 - Don't-care bits never change behaviour
// RULE15 - Initial level applied next clock cycle
package tioms_pkg;

    // Sizes
    localparam int DATA_W  = 16;
    localparam int ADDR_W  = 3;
    localparam int NUM_CH  = 3;
    localparam int MODE_W  = 4;

    // Register indices on the plain port
    localparam logic [ADDR_W-1:0] ADDR_MODE        = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_GREG_CH3C   = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_GREG_CH4A   = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_GREG_CH5A   = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_PIN_STATUS  = 3'h4;

    // Field positions in the mode register
    localparam int MODE_CH3C_LSB = 0;
    localparam int MODE_CH4A_LSB = 4;
    localparam int MODE_CH5A_LSB = 8;
    localparam int BFA_BIT       = 12;

    // Bit positions inside one mode field
    localparam int MODE_CAPTURE_BIT = 3;
    localparam int MODE_SOURCE_BIT  = 2;
    localparam int MODE_BOTH_BIT    = 1;
    localparam int MODE_FALL_BIT    = 0;

    // Pin status field positions
    localparam int STAT_LEVEL_LSB = 0;
    localparam int STAT_OE_LSB    = 3;
    localparam int STAT_IN_LSB    = 6;

    // Values after reset
    localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;
    localparam logic [DATA_W-1:0] GREG_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] RDATA_RESET = 16'h0000;
    localparam logic              BFA_RESET  = 1'b0;
    localparam logic              PIN_RESET  = 1'b0;

    // Compare actions, low pair of a compare code
    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_LOW    = 2'h1;
    localparam logic [1:0] ACT_HIGH   = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;

    // Channel 3 C and 4 A have a cross source; channel 5 A has none
    localparam logic [NUM_CH-1:0] CROSS_SRC_EN = 3'h3;
    // Cycles from a mode write to its initial pin level
    localparam int INIT_LEVEL_CYCLES = 1;

    // Register port request
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } tioms_bus_req_t;

    // Drive of one compare pin
    typedef struct packed {
        logic level;
        logic oe;
    } tioms_pin_drv_t;

endpackage : tioms_pkg

// [logic/tioms_pin_sync.sv]
`timescale 1ns/10ps
module tioms_pin_sync
    import tioms_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Raw pin
    input  wire logic pin_in,
    // Filtered level and edge pulses
    output logic      level,
    output logic      rise,
    output logic      fall
);

    logic stage1;
    logic stage2;
    logic stage3;

    // Three stages; the first feeds only the second
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            stage1 <= PIN_RESET;
            stage2 <= PIN_RESET;
            stage3 <= PIN_RESET;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Level moves only when the last two stages agree, so one-cycle glitches drop
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            level <= PIN_RESET;
            rise  <= 1'b0;
            fall  <= 1'b0;
        end else begin
            rise <= (stage2 == stage3) && stage2 && !level;
            fall <= (stage2 == stage3) && !stage2 && level;
            if (stage2 == stage3) begin
                level <= stage2;
            end
        end
    end

endmodule : tioms_pin_sync

// [logic/tioms_io_mode_select.sv]
`timescale 1ns/10ps
module tioms_io_mode_select
    import tioms_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    // Register port
    input  wire tioms_bus_req_t    bus_req,
    output logic [DATA_W-1:0]      rd_data,
    // Counters from the neighbouring channels
    input  wire logic [DATA_W-1:0] ch3_counter,
    input  wire logic [DATA_W-1:0] ch4_counter,
    input  wire logic [DATA_W-1:0] ch5_counter,
    // Cross-channel events, same clock
    input  wire logic              ch4_count_pulse,
    input  wire logic              ch3_reg_a_event,
    // Pins, inputs
    input  wire logic              ch3_pin_c_in,
    input  wire logic              ch4_pin_a_in,
    input  wire logic              ch5_pin_a_in,
    // Pins, outputs
    output tioms_pin_drv_t         ch3_pin_c_drv,
    output tioms_pin_drv_t         ch4_pin_a_drv,
    output tioms_pin_drv_t         ch5_pin_a_drv,
    // Compare match or capture pulses for the status flags
    output logic [NUM_CH-1:0]      ch_event
);

    // Mode fields and buffer mode enable
    logic [MODE_W-1:0] mode [NUM_CH];
    logic [MODE_W-1:0] next_mode [NUM_CH];
    logic              buffer_mode_a_enable;
    logic              mode_wr;

    // Per-channel views packed for the generate loop
    logic [DATA_W-1:0] counter   [NUM_CH];
    logic [DATA_W-1:0] greg      [NUM_CH];
    logic [NUM_CH-1:0] pin_raw;
    logic [NUM_CH-1:0] pin_level;
    logic [NUM_CH-1:0] pin_rise;
    logic [NUM_CH-1:0] pin_fall;
    logic [NUM_CH-1:0] cross_evt;
    logic [NUM_CH-1:0] inhibit;
    logic [NUM_CH-1:0] drv_level;
    logic [NUM_CH-1:0] drv_oe;
    logic [NUM_CH-1:0] greg_wr;

    // Channel wiring
    assign counter[0] = ch3_counter;
    assign counter[1] = ch4_counter;
    assign counter[2] = ch5_counter;
    assign pin_raw    = {ch5_pin_a_in, ch4_pin_a_in, ch3_pin_c_in};
    assign cross_evt  = {1'b0, ch3_reg_a_event, ch4_count_pulse}; // [RULE11] [RULE12]
    assign inhibit    = {1'b0, 1'b0, buffer_mode_a_enable};       // [RULE13]

    // Register write decode
    assign mode_wr    = bus_req.wr && (bus_req.addr == ADDR_MODE);
    assign greg_wr[0] = bus_req.wr && (bus_req.addr == ADDR_GREG_CH3C);
    assign greg_wr[1] = bus_req.wr && (bus_req.addr == ADDR_GREG_CH4A);
    assign greg_wr[2] = bus_req.wr && (bus_req.addr == ADDR_GREG_CH5A);

    // Mode value after this edge; pin logic looks at it so levels land with the write
    always_comb begin
        next_mode[0] = mode[0];
        next_mode[1] = mode[1];
        next_mode[2] = mode[2];
        if (mode_wr) begin
            next_mode[0] = bus_req.wdata[MODE_CH3C_LSB +: MODE_W];
            next_mode[1] = bus_req.wdata[MODE_CH4A_LSB +: MODE_W];
            next_mode[2] = bus_req.wdata[MODE_CH5A_LSB +: MODE_W];
        end
    end

    // Mode register, all-zero after reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mode[0]              <= MODE_RESET; // [RULE1]
            mode[1]              <= MODE_RESET;
            mode[2]              <= MODE_RESET;
            buffer_mode_a_enable <= BFA_RESET;
        end else begin
            mode[0] <= next_mode[0];
            mode[1] <= next_mode[1];
            mode[2] <= next_mode[2];
            if (mode_wr) begin
                buffer_mode_a_enable <= bus_req.wdata[BFA_BIT];
            end
        end
    end

    // One compare/capture unit per channel
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        logic [DATA_W-1:0] greg_q;
        logic [DATA_W-1:0] counter_prev;
        logic              level_q;
        logic              oe_q;
        logic              event_q;
        logic              is_compare;
        logic              next_is_compare;
        logic              oc_active;
        logic              next_oc_active;
        logic              cross_sel;
        logic              pin_evt;
        logic              match;
        logic              capture;

        // Edge filter for this channel's pin
        tioms_pin_sync u_sync (
            .clk     (clk),
            .reset_n (reset_n),
            .pin_in  (pin_raw[ch]),
            .level   (pin_level[ch]),
            .rise    (pin_rise[ch]),
            .fall    (pin_fall[ch])
        );

        // Compare when top bit is clear; pair 00 means output disabled
        assign is_compare      = !mode[ch][MODE_CAPTURE_BIT];      // [RULE1]
        assign next_is_compare = !next_mode[ch][MODE_CAPTURE_BIT];
        assign oc_active       = is_compare && (mode[ch][1:0] != ACT_NONE) && !inhibit[ch];
        assign next_oc_active  = next_is_compare && (next_mode[ch][1:0] != ACT_NONE)
                                 && !inhibit[ch];                  // [RULE3] [RULE13]

        // Match on the cycle the counter arrives at the value, not while it rests there
        assign match = oc_active && (counter[ch] == greg_q) && (counter[ch] != counter_prev);

        // Cross source only where the channel has one; channel 5 treats bit 2 as don't-care
        assign cross_sel = mode[ch][MODE_SOURCE_BIT] && CROSS_SRC_EN[ch]; // [RULE14]

        // Pin edge choice; bit 0 ignored when both edges are selected
        always_comb begin
            if (mode[ch][MODE_BOTH_BIT]) begin
                pin_evt = pin_rise[ch] || pin_fall[ch];            // [RULE10] [RULE14]
            end else if (mode[ch][MODE_FALL_BIT]) begin
                pin_evt = pin_fall[ch];                            // [RULE9]
            end else begin
                pin_evt = pin_rise[ch];                            // [RULE9]
            end
        end

        // Capture event from the selected source
        assign capture = !is_compare && !inhibit[ch]               // [RULE7] [RULE13]
                         && (cross_sel ? cross_evt[ch] : pin_evt); // [RULE8] [RULE11] [RULE12]

        // Last counter sample for the arrival test
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                counter_prev <= GREG_RESET;
            end else begin
                counter_prev <= counter[ch];
            end
        end

        // General register; capture beats a software write in the same cycle
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                greg_q <= GREG_RESET;
            end else if (capture) begin
                greg_q <= counter[ch];                             // [RULE7]
            end else if (greg_wr[ch]) begin
                greg_q <= bus_req.wdata;
            end
        end

        // Pin level: a mode write that enables a compare output sets the initial level, otherwise matches act
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                level_q <= PIN_RESET;
            end else if (mode_wr && next_oc_active) begin
                level_q <= next_mode[ch][MODE_SOURCE_BIT];         // [RULE2] [RULE3] [RULE15]
            end else if (match) begin
                unique case (mode[ch][1:0])
                    ACT_LOW:    level_q <= 1'b0;                   // [RULE4]
                    ACT_HIGH:   level_q <= 1'b1;                   // [RULE5]
                    ACT_TOGGLE: level_q <= !level_q;               // [RULE6]
                    default:    level_q <= level_q;
                endcase
            end
        end

        // Enable follows the mode taking effect, same edge as the level
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                oe_q <= 1'b0;                                      // [RULE1]
            end else begin
                oe_q <= next_oc_active;                            // [RULE15]
            end
        end

        // Event pulse for the neighbouring flag logic
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                event_q <= 1'b0;
            end else begin
                event_q <= match || capture;
            end
        end

        assign greg[ch]      = greg_q;
        assign drv_level[ch] = level_q;
        assign drv_oe[ch]    = oe_q;
        assign ch_event[ch]  = event_q;
    end

    // Pin drives come straight from the per-channel flops
    assign ch3_pin_c_drv = '{level: drv_level[0], oe: drv_oe[0]};
    assign ch4_pin_a_drv = '{level: drv_level[1], oe: drv_oe[1]};
    assign ch5_pin_a_drv = '{level: drv_level[2], oe: drv_oe[2]};

    // Read data stand one cycle after the strobe and read zero otherwise
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rd_data <= RDATA_RESET;
        end else if (bus_req.rd) begin
            rd_data <= RDATA_RESET;
            unique case (bus_req.addr)
                ADDR_MODE: begin
                    rd_data[MODE_CH3C_LSB +: MODE_W] <= mode[0];
                    rd_data[MODE_CH4A_LSB +: MODE_W] <= mode[1];
                    rd_data[MODE_CH5A_LSB +: MODE_W] <= mode[2];
                    rd_data[BFA_BIT]                 <= buffer_mode_a_enable;
                end
                ADDR_GREG_CH3C: rd_data <= greg[0];
                ADDR_GREG_CH4A: rd_data <= greg[1];
                ADDR_GREG_CH5A: rd_data <= greg[2];
                ADDR_PIN_STATUS: begin
                    rd_data[STAT_LEVEL_LSB +: NUM_CH] <= drv_level;
                    rd_data[STAT_OE_LSB +: NUM_CH]    <= drv_oe;
                    rd_data[STAT_IN_LSB +: NUM_CH]    <= pin_level;
                end
                default: rd_data <= RDATA_RESET;
            endcase
        end else begin
            rd_data <= RDATA_RESET;
        end
    end

endmodule : tioms_io_mode_select

// [dv/tioms_io_mode_select_sva.sv]
`timescale 1ns/10ps
module tioms_io_mode_select_sva
    import tioms_pkg::*;
(
    // Clock and reset
    input wire logic              clk,
    input wire logic              reset_n,
    // Register port and cross event
    input wire tioms_bus_req_t    bus_req,
    input wire logic [DATA_W-1:0] rd_data,
    input wire logic              ch4_count_pulse,
    // Pins and event pulses
    input wire logic              ch5_pin_a_in,
    input wire tioms_pin_drv_t    ch3_pin_c_drv,
    input wire tioms_pin_drv_t    ch5_pin_a_drv,
    input wire logic [NUM_CH-1:0] ch_event
);
    logic [12:0] m;
    wire         mw = bus_req.wr && bus_req.addr == ADDR_MODE;
    wire [3:0]   f5 = bus_req.wdata[11:8];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Shadow of the mode register, so checks see the live codes
    always_ff @(posedge clk) begin
        if (!reset_n)
            m <= 13'h0000;
        else if (mw)
            m <= bus_req.wdata[12:0];
    end

    a_read_window:
        assert property (!$past(bus_req.rd) |-> rd_data == 16'h0000) else $error("stray read data");
    a_init_low:
        assert property (mw && f5[3:2] == 2'h0 && f5[1:0] != 2'h0
            |=> ch5_pin_a_drv.oe && !ch5_pin_a_drv.level) else $error("initial low missing");
    a_init_high:
        assert property (mw && f5[3:2] == 2'h1 && f5[1:0] != 2'h0
            |=> ch5_pin_a_drv.oe && ch5_pin_a_drv.level) else $error("initial high missing");
    a_match_set:
        assert property (ch_event[2] && !$past(mw) && !m[11] && m[9:8] != 2'h3
            |-> ch5_pin_a_drv.level == m[9]) else $error("match level wrong");
    a_match_toggle:
        assert property (ch_event[2] && !$past(mw) && !m[11] && m[9:8] == 2'h3
            |-> ch5_pin_a_drv.level != $past(ch5_pin_a_drv.level)) else $error("no toggle");
    a_cap_rise:
        assert property (m[11:8] == 4'h8 && $rose(ch5_pin_a_in)
            |-> ##[4:6] ch_event[2]) else $error("rising capture missing");
    a_cross_count:
        assert property (m[3:2] == 2'h3 && !m[12] && ch4_count_pulse
            |=> ch_event[0]) else $error("count capture missing");
    a_buffer_quiet:
        assert property (m[12] && $past(m[12], 2)
            |-> !ch3_pin_c_drv.oe && !ch_event[0]) else $error("buffered slot active");
endmodule : tioms_io_mode_select_sva

bind tioms_io_mode_select tioms_io_mode_select_sva chk (
    .clk(clk), .reset_n(reset_n), .bus_req(bus_req), .rd_data(rd_data),
    .ch4_count_pulse(ch4_count_pulse), .ch5_pin_a_in(ch5_pin_a_in),
    .ch3_pin_c_drv(ch3_pin_c_drv), .ch5_pin_a_drv(ch5_pin_a_drv), .ch_event(ch_event)
);

// [dv/tioms_pin_model.sv]
`timescale 1ns/10ps
module tioms_pin_model
    import tioms_pkg::*;
(
    // Device drives
    input  wire tioms_pin_drv_t    d3,
    input  wire tioms_pin_drv_t    d4,
    input  wire tioms_pin_drv_t    d5,
    // Outside sources
    input  wire logic [NUM_CH-1:0] ext,
    // Resolved pin levels
    output logic [NUM_CH-1:0]      pin
);
    // Driven pin follows the device; the source must be released then
    assign pin[0] = d3.oe ? d3.level : ext[0];
    assign pin[1] = d4.oe ? d4.level : ext[1];
    assign pin[2] = d5.oe ? d5.level : ext[2];
endmodule : tioms_pin_model

// [dv/test_timer_io_mode_select_ch3_to_5.sv]
`timescale 1ns/10ps
module test_timer_io_mode_select_ch3_to_5
    import tioms_pkg::*;
;
    logic           clk       = 1'b0;
    logic           reset_n   = 1'b0;
    tioms_bus_req_t req       = '0;
    logic [15:0]    rd_data;
    logic [15:0]    c3        = 16'h0000;
    logic [15:0]    c4        = 16'h0000;
    logic [15:0]    c5        = 16'h0000;
    logic           cnt_p     = 1'b0;
    logic           ev3a      = 1'b0;
    logic [2:0]     ext       = 3'h0;
    logic [2:0]     pin;
    logic [2:0]     evt;
    tioms_pin_drv_t d3;
    tioms_pin_drv_t d4;
    tioms_pin_drv_t d5;
    int             bad_count = 0;
    int             compares  = 0;
    // Code, initial {oe, level}, after match {oe, level, event}
    logic [8:0]     rows [8]  = '{9'h035, 9'h057, 9'h077, 9'h080, 9'h0BD, 9'h0DF, 9'h0FD, 9'h000};
    // Code, captures on rise, captures on fall
    logic [5:0]     caps [6]  = '{6'h22, 6'h25, 6'h2B, 6'h2F, 6'h32, 6'h35};

    // Free-running clock
    always #12.5 clk = ~clk;

    tioms_io_mode_select dut (
        .clk(clk), .reset_n(reset_n), .bus_req(req), .rd_data(rd_data),
        .ch3_counter(c3), .ch4_counter(c4), .ch5_counter(c5),
        .ch4_count_pulse(cnt_p), .ch3_reg_a_event(ev3a),
        .ch3_pin_c_in(pin[0]), .ch4_pin_a_in(pin[1]), .ch5_pin_a_in(pin[2]),
        .ch3_pin_c_drv(d3), .ch4_pin_a_drv(d4), .ch5_pin_a_drv(d5), .ch_event(evt)
    );

    tioms_pin_model far (.d3(d3), .d4(d4), .d5(d5), .ext(ext), .pin(pin));

    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        req <= '0;
    endtask : wr

    // Read data is only valid in the cycle after the strobe
    task rd(input logic [2:0] a, input logic [15:0] e);
        @(posedge clk);
        req <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge clk);
        req <= '0;
        @(negedge clk);
        chk(rd_data, e);
    endtask : rd

    // Channel 5 counter arrives at 0x0010, then looks at the cycle after the match
    task hit;
        @(posedge clk);
        c5 <= 16'h000F;
        @(posedge clk);
        c5 <= 16'h0010;
        @(posedge clk);
        @(negedge clk);
    endtask : hit

    task stop_test;
        $display("Compares %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test

    // Watchdog, far beyond the roughly 260 cycles the run needs
    initial begin
        #100000;
        bad_count++;
        stop_test;
    end

    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        chk(16'({d3, d4, d5, evt}), 16'h0000);
        rd(3'h0, 16'h0000);
        wr(3'h5, 16'hFFFF);
        rd(3'h5, 16'h0000);
        wr(3'h3, 16'h0010);
        foreach (rows[i]) begin
            wr(3'h0, {4'h0, rows[i][8:5], 8'h00});
            @(negedge clk);
            chk(16'({d5.oe, d5.level & d5.oe}), 16'(rows[i][4:3]));
            hit;
            chk(16'({d5.oe, d5.level & d5.oe, evt[2]}), 16'(rows[i][2:0]));
        end
        wr(3'h0, 16'h0300);
        hit;
        chk(16'(d5.level), 16'h0001);
        // Driven high pin needs four edges through the filter before status shows it
        repeat (4) @(posedge clk);
        rd(3'h4, 16'h0124);
        hit;
        chk(16'(d5.level), 16'h0000);
        foreach (caps[i]) begin
            wr(3'h0, {4'h0, caps[i][5:2], 8'h00});
            wr(3'h3, 16'h0000);
            c5 <= 16'h00A1;
            ext[2] <= 1'b1;
            repeat (8) @(posedge clk);
            rd(3'h3, caps[i][1] ? 16'h00A1 : 16'h0000);
            @(posedge clk);
            c5 <= 16'h00B2;
            ext[2] <= 1'b0;
            repeat (8) @(posedge clk);
            rd(3'h3, caps[i][0] ? 16'h00B2 : 16'(caps[i][1] ? 8'hA1 : 8'h00));
        end
        wr(3'h0, 16'h00CC);
        c3 <= 16'h0033;
        c4 <= 16'h0044;
        cnt_p <= 1'b1;
        ev3a <= 1'b1;
        @(posedge clk);
        cnt_p <= 1'b0;
        ev3a <= 1'b0;
        @(negedge clk);
        chk(16'(evt), 16'h0003);
        rd(3'h1, 16'h0033);
        rd(3'h2, 16'h0044);
        // Compare codes on the two cross-capable channels drive high at once
        wr(3'h0, 16'h0055);
        @(negedge clk);
        chk(16'({d3, d4}), 16'h000F);
        wr(3'h0, 16'h100C);
        wr(3'h1, 16'h0000);
        c3 <= 16'h0055;
        cnt_p <= 1'b1;
        @(posedge clk);
        cnt_p <= 1'b0;
        rd(3'h1, 16'h0000);
        wr(3'h0, 16'h1005);
        @(negedge clk);
        chk(16'(d3.oe), 16'h0000);
        // Mid-run reset must clear drives, modes, buffer bit and registers
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        chk(16'({d3, d4, d5, evt}), 16'h0000);
        rd(3'h0, 16'h0000);
        rd(3'h3, 16'h0000);
        stop_test;
    end
endmodule : test_timer_io_mode_select_ch3_to_5
